// ---- rtl/ofic_params.svh ----
/*
  constants for the option fault and input function controller.
  assumes a 10 MHz core clock.
*/
// Contract
// - comm error action: 0 ramp, 1 coast default, 2 fast stop, 3 alarm only.
// - option card comm errors act whatever the command source is.
// - alarm-only comm error leaves fault output off; other actions energize it.
// - built-in serial errors are ignored by the comm error action.
// - ext fault detect 0 always, 1 only while running.
// - ext fault stop: 0 ramp, 1 coast default, 2 fast stop, 3 alarm only.
// - recognized ext fault with stop not 3 faults and starts stopping.
// - recognized ext fault alarm-only keeps running and flashes fault code.
// - current monitor is amperes when scaling 0, 8192 equals rated when 1.
// - five contact inputs, each with function code 00 to 6E.
// - defaults 24,14 then 3,4,6 two-wire or 0,3,4 three-wire.
// - decoder maps listed codes to their functions.
// - three-wire input open forward, closed reverse.
// - three-wire: run pushbutton runs, stop pushbutton stops.
// - run latches after run pushbutton held 50 ms.
// - code 1 has no effect.
// - code 2 open selects terminals, closed selects option card.
// - command source changes only while stopped.
// - multi-step bits pick speeds 1 to 4; jog overrides.
// - jog only changes speed command, run still needed.
`ifndef OFIC_PARAMS_SVH
`define OFIC_PARAMS_SVH
`define OFIC_ACT_RAMP      2'h0
`define OFIC_ACT_COAST     2'h1
`define OFIC_ACT_FAST      2'h2
`define OFIC_ACT_ALARM     2'h3
`define OFIC_FN_3WIRE      8'h00
`define OFIC_FN_LOCREM     8'h01
`define OFIC_FN_SRCSEL     8'h02
`define OFIC_FN_STEP1      8'h03
`define OFIC_FN_STEP2      8'h04
`define OFIC_FN_JOG        8'h06
`define OFIC_FN_ACCSET     8'h07
`define OFIC_FN_BBNO       8'h08
`define OFIC_FN_BBNC       8'h09
`define OFIC_FN_FRESET     8'h14
`define OFIC_FN_FSNO       8'h15
`define OFIC_FN_FSNC       8'h17
`define OFIC_FN_MAX        8'h6E
`define OFIC_DEF_IN3       8'h24
`define OFIC_DEF_IN4       8'h14
`define OFIC_FULL_SCALE    16'h2000
`define OFIC_CLK_HZ        10000000
`define OFIC_RUN_HOLD_MS   50
`define OFIC_RUN_HOLD_CYC  ((`OFIC_CLK_HZ / 1000) * `OFIC_RUN_HOLD_MS)
`endif

// ---- rtl/ofic_pkg.sv ----
/*
  types of the option fault and input function controller.
  assumes nothing beyond the params header.
*/
`default_nettype none
package ofic_pkg;
  typedef enum logic [1:0] {
    OFIC_RAMP  = 2'b00,
    OFIC_COAST = 2'b01,
    OFIC_FAST  = 2'b10,
    OFIC_ALARM = 2'b11
  } ofic_stop_t;
  typedef enum logic [1:0] {
    OFIC_ST_IDLE  = 2'b00,
    OFIC_ST_RUN   = 2'b01,
    OFIC_ST_STOP  = 2'b10,
    OFIC_ST_FAULT = 2'b11
  } ofic_state_t;
endpackage : ofic_pkg
`default_nettype wire

// ---- rtl/ofic_input_decode.sv ----
/*
  decodes one contact input by its function code into function flags.
  assumes input and code are already registered in core_clk.
*/
`default_nettype none
`include "ofic_params.svh"
module ofic_input_decode
  import ofic_pkg::*;
(
  // function
  input  wire logic [7:0] code,
  input  wire logic       level,
  // decoded flags
  output logic            dir,
  output logic            srcSel,
  output logic            step1,
  output logic            step2,
  output logic            jog,
  output logic            accSet,
  output logic            baseBlock,
  output logic            faultReset,
  output logic            fastStop,
  output logic            extFault
);
  always_comb begin
    dir        = 1'b0;
    srcSel     = 1'b0;
    step1      = 1'b0;
    step2      = 1'b0;
    jog        = 1'b0;
    accSet     = 1'b0;
    baseBlock  = 1'b0;
    faultReset = 1'b0;
    fastStop   = 1'b0;
    extFault   = 1'b0;
    case (code)
      `OFIC_FN_3WIRE:  dir        = level;
      `OFIC_FN_LOCREM: ;
      `OFIC_FN_SRCSEL: srcSel     = level;
      `OFIC_FN_STEP1:  step1      = level;
      `OFIC_FN_STEP2:  step2      = level;
      `OFIC_FN_JOG:    jog        = level;
      `OFIC_FN_ACCSET: accSet     = level;
      `OFIC_FN_BBNO:   baseBlock  = level;
      `OFIC_FN_BBNC:   baseBlock  = ~level;
      `OFIC_FN_FRESET: faultReset = level;
      `OFIC_FN_FSNO:   fastStop   = level;
      `OFIC_FN_FSNC:   fastStop   = ~level;
      default: begin
        if (code[7:4] == 4'h2) begin
          extFault = level;
        end
      end
    endcase
  end
endmodule : ofic_input_decode
`default_nettype wire

// ---- rtl/ofic_ctrl.sv ----
/*
  option card fault handling, current scaling and contact input functions.
  assumes all inputs synchronous to core_clk; motor control lies outside.
*/
`default_nettype none
`include "ofic_params.svh"
module ofic_ctrl
  import ofic_pkg::*;
#(
  parameter int RUN_HOLD_CYC = `OFIC_RUN_HOLD_CYC
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // settings
  input  wire logic [1:0]  commErrorActionSel,
  input  wire logic        extFaultDetectSel,
  input  wire logic [1:0]  extFaultStopSel,
  input  wire logic        currentScalingSel,
  input  wire logic        threeWireMode,
  input  wire logic        cfgLoad,
  input  wire logic [39:0] inputFunctionSelIn,
  // option card
  input  wire logic        optCommError,
  input  wire logic        optExtFault,
  input  wire logic        serialCommError,
  // current measurement
  input  wire logic [15:0] currentAmps,
  input  wire logic [15:0] ratedAmps,
  // contacts
  input  wire logic        runPushbuttonInput,
  input  wire logic        stopPushbuttonInput,
  input  wire logic [4:0]  contactIn,
  input  wire logic        driveStopped,
  // outputs
  output logic             faultOut,
  output logic             faultActive,
  output ofic_stop_t       stopMode,
  output logic             stopReq,
  output logic             alarmFlash,
  output logic [15:0]      sharedMonitorCurrent,
  output logic             runCmd,
  output logic             reverse,
  output logic             srcOption,
  output logic [2:0]       speedSel,
  output logic             accSetSel,
  output logic             baseBlockOut,
  output logic             fastStopOut,
  output logic [39:0]      inputFunctionSel
);
  localparam int CW = $clog2(RUN_HOLD_CYC + 1);
  logic [4:0]    contactQ;
  logic          runQ;
  logic          stopQ;
  logic          errQ;
  logic          extQ;
  logic [CW-1:0] holdCnt;
  ofic_state_t   state;
  ofic_state_t   next_state;
  logic [4:0]    fDir, fSrc, fS1, fS2, fJog, fAcc, fBb, fRst, fFs, fExt;
  logic          extRecog;
  logic          commEvt;
  logic          anyFaultReset;
  logic          runLatched;

  // registering inputs keeps the decode free of glitches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      contactQ <= 5'h00;
      runQ     <= 1'b0;
      stopQ    <= 1'b0;
      errQ     <= 1'b0;
      extQ     <= 1'b0;
    end else if (clkEn) begin
      contactQ <= contactIn;
      runQ     <= runPushbuttonInput;
      stopQ    <= stopPushbuttonInput;
      errQ     <= optCommError;
      extQ     <= optExtFault;
    end
  end

  // codes above the valid range are refused and the old code kept
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inputFunctionSel <= {`OFIC_FN_JOG, `OFIC_FN_STEP2, `OFIC_FN_STEP1,
                           `OFIC_DEF_IN4, `OFIC_DEF_IN3};
    end else if (clkEn) begin
      if (cfgLoad) begin
        for (int i = 0; i < 5; i++) begin
          if (inputFunctionSelIn[i*8 +: 8] <= `OFIC_FN_MAX) begin
            inputFunctionSel[i*8 +: 8] <= inputFunctionSelIn[i*8 +: 8];
          end
        end
      end else if (threeWireMode && inputFunctionSel[39:16] ==
                   {`OFIC_FN_JOG, `OFIC_FN_STEP2, `OFIC_FN_STEP1}) begin
        inputFunctionSel[39:16] <= {`OFIC_FN_STEP2, `OFIC_FN_STEP1,
                                    `OFIC_FN_3WIRE};
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gDecode
      ofic_input_decode uDec (
        .code       (inputFunctionSel[g*8 +: 8]),
        .level      (contactQ[g]),
        .dir        (fDir[g]),
        .srcSel     (fSrc[g]),
        .step1      (fS1[g]),
        .step2      (fS2[g]),
        .jog        (fJog[g]),
        .accSet     (fAcc[g]),
        .baseBlock  (fBb[g]),
        .faultReset (fRst[g]),
        .fastStop   (fFs[g]),
        .extFault   (fExt[g])
      );
    end
  endgenerate

  assign anyFaultReset = |fRst;
  assign runLatched    = (state == OFIC_ST_RUN);
  // serialCommError is deliberately not used here
  assign commEvt  = errQ;
  assign extRecog = (extQ | (|fExt)) &&
                    (!extFaultDetectSel || runLatched);

  // run pushbutton must be held the full time before the run latches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdCnt <= '0;
    end else if (clkEn) begin
      if (!runQ || stopQ) begin
        holdCnt <= '0;
      end else if (holdCnt != CW'(RUN_HOLD_CYC)) begin
        holdCnt <= holdCnt + CW'(1);
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      OFIC_ST_IDLE: begin
        if (holdCnt == CW'(RUN_HOLD_CYC) && !stopQ) begin
          next_state = OFIC_ST_RUN;
        end
      end
      OFIC_ST_RUN: begin
        if (stopQ) begin
          next_state = OFIC_ST_STOP;
        end
      end
      OFIC_ST_STOP: begin
        if (driveStopped) begin
          next_state = OFIC_ST_IDLE;
        end
      end
      OFIC_ST_FAULT: begin
        if (anyFaultReset) begin
          next_state = OFIC_ST_IDLE;
        end
      end
      default: next_state = OFIC_ST_IDLE;
    endcase
    if ((commEvt && commErrorActionSel != `OFIC_ACT_ALARM) ||
        (extRecog && extFaultStopSel != `OFIC_ACT_ALARM)) begin
      next_state = OFIC_ST_FAULT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= OFIC_ST_IDLE;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // fault output and stop method; comm error takes priority on the method
  always_ff @(posedge core_clk) begin
    if (rst) begin
      faultOut    <= 1'b0;
      faultActive <= 1'b0;
      stopMode    <= OFIC_COAST;
      stopReq     <= 1'b0;
      alarmFlash  <= 1'b0;
      runCmd      <= 1'b0;
    end else if (clkEn) begin
      if (commEvt && commErrorActionSel != `OFIC_ACT_ALARM) begin
        faultOut <= 1'b1;
        stopMode <= ofic_stop_t'(commErrorActionSel);
      end else if (extRecog && extFaultStopSel != `OFIC_ACT_ALARM) begin
        faultOut <= 1'b1;
        stopMode <= ofic_stop_t'(extFaultStopSel);
      end else if (anyFaultReset && state == OFIC_ST_FAULT) begin
        faultOut <= 1'b0;
      end
      faultActive <= (next_state == OFIC_ST_FAULT);
      stopReq     <= (next_state == OFIC_ST_FAULT) || (next_state == OFIC_ST_STOP);
      alarmFlash  <= extRecog && extFaultStopSel == `OFIC_ACT_ALARM;
      runCmd      <= (next_state == OFIC_ST_RUN);
    end
  end

  // direction, source and speed selection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reverse      <= 1'b0;
      srcOption    <= 1'b0;
      speedSel     <= 3'h0;
      accSetSel    <= 1'b0;
      baseBlockOut <= 1'b0;
      fastStopOut  <= 1'b0;
    end else if (clkEn) begin
      reverse <= |fDir;
      if (driveStopped && !runLatched) begin
        srcOption <= |fSrc;
      end
      if (|fJog) begin
        speedSel <= 3'h4;
      end else begin
        speedSel <= {1'b0, |fS2, |fS1};
      end
      accSetSel    <= |fAcc;
      baseBlockOut <= |fBb;
      fastStopOut  <= |fFs;
    end
  end

  // current monitor: amperes when scaling is 0, 8192 stands for rated current when 1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sharedMonitorCurrent <= 16'h0000;
    end else if (clkEn) begin
      if (!currentScalingSel) begin
        sharedMonitorCurrent <= currentAmps;
      end else if (ratedAmps == 16'h0000) begin
        sharedMonitorCurrent <= 16'h0000;
      end else begin
        sharedMonitorCurrent <= 16'(({16'h0000, currentAmps} * 32'(`OFIC_FULL_SCALE))
                                    / {16'h0000, ratedAmps});
      end
    end
  end

  a_alarm_no_fault: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && errQ && commErrorActionSel == `OFIC_ACT_ALARM && !extRecog && !faultOut
    |=> !faultOut) else $error("alarm-only comm error set fault");
  a_comm_fault_set: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && errQ && commErrorActionSel != `OFIC_ACT_ALARM
    |=> faultOut && faultActive) else $error("comm error did not fault");
  a_ext_fault_set: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && extRecog && extFaultStopSel != `OFIC_ACT_ALARM
    |=> faultActive && stopReq) else $error("ext fault did not fault");
  a_ext_alarm_flash: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && extRecog && extFaultStopSel == `OFIC_ACT_ALARM
    |=> alarmFlash) else $error("ext alarm did not flash");
  a_detect_run_only: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && extFaultDetectSel && !runLatched && !errQ && state != OFIC_ST_FAULT
    |=> !faultActive) else $error("ext fault seen while stopped");
  a_src_hold_run: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !driveStopped |=> $stable(srcOption))
    else $error("source changed while running");
  a_jog_priority: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && (|fJog) |=> speedSel == 3'h4) else $error("jog not prioritized");
  a_run_needs_hold: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && state == OFIC_ST_IDLE && holdCnt != CW'(RUN_HOLD_CYC)
    |=> !runCmd) else $error("run latched too early");
  a_scale_amps: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !currentScalingSel |=> sharedMonitorCurrent == $past(currentAmps))
    else $error("amp display wrong");

  // a pending fault event outranks both the run latch and the fault reset
  sequence s_run_ready;
    clkEn && state == OFIC_ST_IDLE && holdCnt == CW'(RUN_HOLD_CYC) && !stopQ &&
    !commEvt && !extRecog;
  endsequence
  sequence s_fault_cleared;
    clkEn && state == OFIC_ST_FAULT && anyFaultReset && !commEvt && !extRecog;
  endsequence
  a_run_latch: assert property (@(posedge core_clk) disable iff (rst)
    s_run_ready |=> runCmd && !stopReq) else $error("held run did not latch");
  a_fault_clear: assert property (@(posedge core_clk) disable iff (rst)
    s_fault_cleared |=> !faultOut && !faultActive) else $error("fault reset ignored");
  a_clken_freeze: assert property (@(posedge core_clk) disable iff (rst)
    !clkEn |=> $stable(state) && $stable(faultOut) && $stable(sharedMonitorCurrent) &&
    $stable(inputFunctionSel)) else $error("state moved while frozen");
  a_three_wire_map: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !cfgLoad && threeWireMode &&
    inputFunctionSel[39:16] == {`OFIC_FN_JOG, `OFIC_FN_STEP2, `OFIC_FN_STEP1}
    |=> inputFunctionSel[39:16] == {`OFIC_FN_STEP2, `OFIC_FN_STEP1, `OFIC_FN_3WIRE})
    else $error("three-wire defaults not applied");
  a_scale_no_rating: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && currentScalingSel && ratedAmps == 16'h0000 |=> sharedMonitorCurrent == 16'h0000)
    else $error("zero rating not cleared");
  a_src_follow: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && driveStopped && !runLatched |=> srcOption == $past(|fSrc))
    else $error("source did not follow input");
endmodule : ofic_ctrl
`default_nettype wire

// ---- tb/ofic_far_side.sv ----
/*
  far side model: option card fault lines and the run pushbutton contact.
  assumes the bench commands it between rising edges of core_clk.
*/
`default_nettype none
module ofic_far_side (
  // clock
  input  wire logic       core_clk,
  // commands from the bench
  input  wire logic       commFail,
  input  wire logic       extTrip,
  input  wire logic       press,
  input  wire logic [7:0] pressLen,
  // lines toward the drive
  output logic            optCommError,
  output logic            optExtFault,
  output logic            runPushbuttonInput
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] holdLeft = 8'h00;
  initial begin
    optCommError = 1'b0;
    optExtFault = 1'b0;
    runPushbuttonInput = 1'b0;
  end
  always @(posedge core_clk) begin
    optCommError <= commFail;
    optExtFault <= extTrip;
  end
  // a short press is allowed here so the bench can show it is not latched
  always @(posedge core_clk) begin
    holdLeft <= press ? pressLen : (holdLeft != 8'h00 ? holdLeft - 8'h01 : 8'h00);
    runPushbuttonInput <= press || holdLeft > 8'h01;
  end
endmodule : ofic_far_side
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  self-checking bench for the option fault and input function controller.
  assumes rtl package and params header are compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ofic_pkg::*;
  localparam int HOLD = 20;
  logic core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, detectSel = 1'b0, scaleSel = 1'b0;
  logic threeWire = 1'b0, cfgLoad = 1'b0, serialErr = 1'b0, commFail = 1'b0;
  logic extTrip = 1'b0, press = 1'b0, stopIn = 1'b0, driveStopped = 1'b1;
  logic [1:0] commAct = 2'h1, stopSel = 2'h1;
  logic [39:0] codesIn = 40'h0, fnSel;
  logic [15:0] curA = 16'h0, ratedA = 16'h0, monCur;
  logic [4:0] contacts = 5'h00;
  logic [7:0] pressLen = 8'h00;
  logic optCommError, optExtFault, runPb, faultOut, faultActive, stopReq, alarmFlash;
  logic runCmd, reverse, srcOption, accSetSel, baseBlockOut, fastStopOut;
  logic [2:0] speedSel;
  ofic_stop_t stopMode;
  int n_errors = 0, checked = 0;

  always #50 core_clk = ~core_clk;

  ofic_far_side ofic_far_side_inst (.core_clk(core_clk), .commFail(commFail),
    .extTrip(extTrip), .press(press), .pressLen(pressLen), .optCommError(optCommError),
    .optExtFault(optExtFault), .runPushbuttonInput(runPb));

  ofic_ctrl #(.RUN_HOLD_CYC(HOLD)) ofic_ctrl_inst (.core_clk(core_clk), .rst(rst),
    .clkEn(clkEn), .commErrorActionSel(commAct), .extFaultDetectSel(detectSel),
    .extFaultStopSel(stopSel), .currentScalingSel(scaleSel), .threeWireMode(threeWire),
    .cfgLoad(cfgLoad), .inputFunctionSelIn(codesIn), .optCommError(optCommError),
    .optExtFault(optExtFault), .serialCommError(serialErr), .currentAmps(curA),
    .ratedAmps(ratedA), .runPushbuttonInput(runPb), .stopPushbuttonInput(stopIn),
    .contactIn(contacts), .driveStopped(driveStopped), .faultOut(faultOut),
    .faultActive(faultActive), .stopMode(stopMode), .stopReq(stopReq),
    .alarmFlash(alarmFlash), .sharedMonitorCurrent(monCur), .runCmd(runCmd),
    .reverse(reverse), .srcOption(srcOption), .speedSel(speedSel), .accSetSel(accSetSel),
    .baseBlockOut(baseBlockOut), .fastStopOut(fastStopOut), .inputFunctionSel(fnSel));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0h want %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic do_reset();
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(1);
  endtask : do_reset

  // code 14 on input 4 clears the fault state; only a code 14 input or a reset leaves it
  task automatic clear_fault();
    contacts[1] = 1'b1;
    cyc(3);
    contacts[1] = 1'b0;
    cyc(3);
    check(40'(faultOut), 40'h0, "fault cleared");
  endtask : clear_fault

  task automatic test_reset();
    do_reset();
    check(40'(stopMode), 40'(OFIC_COAST), "default stop");
    check(fnSel, 40'h0604031424, "default codes");
    $display("test reset done");
  endtask : test_reset

  task automatic test_comm_error();
    for (int a = 0; a < 4; a++) begin
      commAct = 2'(a);
      commFail = 1'b1;
      cyc(4);
      check(40'(faultOut), 40'(a != 3), "comm fault out");
      if (a != 3) check(40'(stopMode), 40'(a), "comm stop mode");
      commFail = 1'b0;
      cyc(3);
      check(40'(faultOut), 40'(a != 3), "fault held");
      clear_fault();
    end
    serialErr = 1'b1;
    cyc(4);
    check(40'(faultActive), 40'h0, "serial ignored");
    serialErr = 1'b0;
    $display("test comm error done");
  endtask : test_comm_error

  task automatic test_ext_fault();
    detectSel = 1'b1;
    extTrip = 1'b1;
    cyc(4);
    check(40'(faultActive), 40'h0, "trip while idle");
    extTrip = 1'b0;
    detectSel = 1'b0;
    stopSel = 2'h3;
    cyc(3);
    extTrip = 1'b1;
    cyc(4);
    check(40'({alarmFlash, faultActive}), 40'h2, "alarm only trip");
    extTrip = 1'b0;
    cyc(3);
    stopSel = 2'h2;
    extTrip = 1'b1;
    cyc(4);
    check(40'({faultActive, stopReq}), 40'h3, "trip faults");
    check(40'(stopMode), 40'(OFIC_FAST), "trip stop mode");
    extTrip = 1'b0;
    clear_fault();
    contacts[0] = 1'b1;
    cyc(3);
    check(40'(faultActive), 40'h1, "input ext fault");
    contacts[0] = 1'b0;
    clear_fault();
    $display("test ext fault done");
  endtask : test_ext_fault

  task automatic test_scaling();
    curA = 16'h0123;
    ratedA = 16'h0200;
    cyc(3);
    check(40'(monCur), 40'h0123, "amps");
    scaleSel = 1'b1;
    cyc(3);
    check(40'(monCur), 40'h1230, "scaled");
    clkEn = 1'b0;
    curA = 16'h0456;
    cyc(3);
    check(40'(monCur), 40'h1230, "frozen");
    clkEn = 1'b1;
    cyc(3);
    check(40'(monCur), 40'h4560, "rescaled");
    ratedA = 16'h0000;
    cyc(3);
    check(40'(monCur), 40'h0, "no rating");
    $display("test scaling done");
  endtask : test_scaling

  task automatic test_three_wire();
    do_reset();
    threeWire = 1'b1;
    cyc(3);
    check(fnSel, 40'h0403001424, "3-wire codes");
    pressLen = 8'd5;
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    cyc(10);
    check(40'(runCmd), 40'h0, "short press");
    pressLen = 8'(HOLD + 4);
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    cyc(HOLD + 10);
    check(40'(runCmd), 40'h1, "latched run");
    driveStopped = 1'b0;
    contacts[2] = 1'b1;
    cyc(3);
    check(40'(reverse), 40'h1, "reverse");
    codesIn = 40'h0203001424;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    contacts = 5'h10;
    cyc(3);
    check(40'({reverse, srcOption}), 40'h0, "fwd, no switch run");
    stopIn = 1'b1;
    cyc(3);
    check(40'(runCmd), 40'h0, "stopped");
    stopIn = 1'b0;
    driveStopped = 1'b1;
    cyc(4);
    check(40'(srcOption), 40'h1, "option source");
    contacts = 5'h00;
    cyc(3);
    check(40'(srcOption), 40'h0, "terminal source");
    $display("test three wire done");
  endtask : test_three_wire

  task automatic test_decode();
    threeWire = 1'b0;
    do_reset();
    for (int p = 0; p < 8; p++) begin
      contacts = 5'(p << 2);
      cyc(3);
      check(40'(speedSel), (p > 3) ? 40'h4 : 40'(p), "step select");
      check(40'(runCmd), 40'h0, "jog no run");
    end
    codesIn = 40'h6F01150807;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    cyc(2);
    check(fnSel, 40'h0601150807, "bad code kept");
    contacts = 5'h1F;
    cyc(3);
    check(40'({accSetSel, baseBlockOut, fastStopOut, runCmd}), 40'hE, "flags");
    codesIn = 40'h0F0F0F0F0F;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    cyc(3);
    check(40'({accSetSel, baseBlockOut, fastStopOut, speedSel}), 40'h0, "no fn");
    codesIn = 40'h0F0F0F1709;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
    contacts = 5'h00;
    cyc(3);
    check(40'({baseBlockOut, fastStopOut}), 40'h3, "nc open");
    contacts = 5'h03;
    cyc(3);
    check(40'({baseBlockOut, fastStopOut}), 40'h0, "nc closed");
    contacts = 5'h00;
    $display("test decode done");
  endtask : test_decode

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    print_verdict();
  end

  initial begin
    test_reset();
    test_comm_error();
    test_ext_fault();
    test_scaling();
    test_three_wire();
    test_decode();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
